// ### shared/hpsc_defs.svh
`ifndef HPSC_DEFS_SVH
`define HPSC_DEFS_SVH

`define HPSC_OFS_SLOT_CAP   12'h07C
`define HPSC_OFS_SLOT_CTL   12'h080

`define HPSC_BIT_ATTN_BTN   0
`define HPSC_BIT_PWR_CTL    1
`define HPSC_BIT_LATCH_SNS  2
`define HPSC_BIT_ATTN_IND   3
`define HPSC_BIT_PWR_IND    4
`define HPSC_BIT_SURPRISE   5
`define HPSC_BIT_HP_CAP     6
`define HPSC_PLV_LSB        7
`define HPSC_PLV_MSB        14
`define HPSC_PLS_LSB        15
`define HPSC_PLS_MSB        16
`define HPSC_BIT_INTERLOCK  17
`define HPSC_BIT_NO_CMD_CPL 18
`define HPSC_PSN_LSB        19
`define HPSC_PSN_MSB        31
`define HPSC_PSN_HI_LSB     24
`define HPSC_PSN_STRAP_MSB  21

`define HPSC_BIT_ABP_EN     0
`define HPSC_BIT_PF_EN      1

`define HPSC_RST_PLV        8'h19
`define HPSC_RST_PLS        2'h0
`define HPSC_RST_SURPRISE   1'b0
`define HPSC_RST_INTERLOCK  1'b1
`define HPSC_RST_PSN        13'h0000

`define HPSC_PM_D0          2'h0
`define HPSC_PM_D3HOT       2'h3

`endif

// ### shared/hpsc_pkg.sv
`default_nettype none
package hpsc_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hpsc_cfg_req_t;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
  } hpsc_ee_wr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } hpsc_msg_t;

  typedef enum logic {
    HPSC_MSG_IDLE = 1'b0,
    HPSC_MSG_SEND = 1'b1
  } hpsc_msg_state_t;

  typedef struct packed {
    hpsc_msg_state_t state;
    logic            again;
    hpsc_msg_t       msg;
  } hpsc_msg_regs_t;

  typedef struct packed {
    logic [7:0]  plv;
    logic [1:0]  pls;
    logic        surprise;
    logic        interlock;
    logic [12:0] slot_num;
    logic        abp_en;
    logic        pf_en;
    logic        dll_up;
    logic [31:0] rdata;
    logic        rvalid;
    logic        led_n;
    logic        int_p;
    logic        pme_p;
  } hpsc_regs_t;

endpackage
`default_nettype wire

// ### hw/hpsc_msg_gen.sv
`timescale 1ns/1ps
`default_nettype none
module hpsc_msg_gen
  import hpsc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       trig_in,
  input  wire logic [7:0] value_in,
  input  wire logic [1:0] scale_in,
  input  wire logic       ready_in,
  output var hpsc_msg_t   msg_out
);

  hpsc_msg_regs_t s_q;
  hpsc_msg_regs_t s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.state)
      HPSC_MSG_IDLE: begin
        if (trig_in) begin
          s_d.state     = HPSC_MSG_SEND;
          s_d.msg.valid = 1'b1;
          s_d.msg.value = value_in;
          s_d.msg.scale = scale_in;
        end
      end
      HPSC_MSG_SEND: begin
        // a new trigger while a message waits sends once more with the newest fields
        if (trig_in) begin
          s_d.again = 1'b1;
        end
        if (ready_in) begin
          if (s_q.again || trig_in) begin
            s_d.again     = 1'b0;
            s_d.msg.value = value_in;
            s_d.msg.scale = scale_in;
          end else begin
            s_d.state     = HPSC_MSG_IDLE;
            s_d.msg.valid = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{state: HPSC_MSG_IDLE, again: 1'b0, msg: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign msg_out = s_q.msg;

endmodule
`default_nettype wire

// ### hw/hpsc_slot_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpsc_defs.svh"
module hpsc_slot_regs
  import hpsc_pkg::*;
(
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       IS_DOWNSTREAM_IN,
  input  wire logic       PARALLEL_HP_IN,
  input  wire logic       SERIAL_PORT_IN,
  input  wire logic       EXPANDER_FOUND_IN,
  input  wire logic [2:0] STRAP_ADDR_IN,
  input  wire logic [7:0] EXP_SLOT_HI_IN,
  input  wire logic       DLL_UP_IN,
  input  wire logic [1:0] PWR_STATE_IN,
  input  wire logic       BUTTON_EVT_IN,
  input  wire logic       FAULT_EVT_IN,
  input  wire logic       PWR_IND_ON_IN,
  input  wire hpsc_cfg_req_t CFG_REQ_IN,
  input  wire hpsc_ee_wr_t   EE_WR_IN,
  input  wire logic       MSG_READY_IN,
  output logic [31:0]     CFG_RDATA_OUT,
  output logic            CFG_RVALID_OUT,
  output logic            SLOT_POWER_LED_N_OUT,
  output logic            NOTIFY_INT_OUT,
  output logic            NOTIFY_PME_OUT,
  output var hpsc_msg_t   MSG_OUT
);

  hpsc_regs_t r_q;
  hpsc_regs_t r_d;

  logic        serial_hp;
  logic        hp_cap;
  logic [12:0] slot_num_view;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [1:0]  evt_in;
  logic [1:0]  evt_en;
  logic [1:0]  evt_fire;
  logic        ee_cap_wr;
  logic        ee_ctl_wr;
  logic        sw_ctl_wr;
  logic        msg_trig;

  assign serial_hp = IS_DOWNSTREAM_IN & SERIAL_PORT_IN & EXPANDER_FOUND_IN;
  assign hp_cap    = IS_DOWNSTREAM_IN & (PARALLEL_HP_IN | serial_hp);

  always_comb begin
    slot_num_view = r_q.slot_num;
    if (serial_hp) begin
      slot_num_view[12:5] = EXP_SLOT_HI_IN;
    end else begin
      slot_num_view[2:0]  = STRAP_ADDR_IN;
      slot_num_view[12:8] = 5'h00;
    end
  end

  always_comb begin
    cap_word = 32'h0000_0000;
    if (IS_DOWNSTREAM_IN) begin
      cap_word[`HPSC_BIT_ATTN_BTN]  = hp_cap;
      cap_word[`HPSC_BIT_PWR_CTL]   = hp_cap;
      cap_word[`HPSC_BIT_LATCH_SNS] = hp_cap;
      cap_word[`HPSC_BIT_ATTN_IND]  = hp_cap;
      cap_word[`HPSC_BIT_PWR_IND]   = hp_cap;
      cap_word[`HPSC_BIT_SURPRISE]  = r_q.surprise;
      cap_word[`HPSC_BIT_HP_CAP]    = hp_cap;
      cap_word[`HPSC_PLV_MSB:`HPSC_PLV_LSB] = r_q.plv;
      cap_word[`HPSC_PLS_MSB:`HPSC_PLS_LSB] = r_q.pls;
      cap_word[`HPSC_BIT_INTERLOCK] = serial_hp & r_q.interlock;
      cap_word[`HPSC_BIT_NO_CMD_CPL] = 1'b0;
      cap_word[`HPSC_PSN_MSB:`HPSC_PSN_LSB] = slot_num_view;
    end
  end

  always_comb begin
    ctl_word = 32'h0000_0000;
    if (IS_DOWNSTREAM_IN) begin
      ctl_word[`HPSC_BIT_ABP_EN] = r_q.abp_en & cap_word[`HPSC_BIT_ATTN_BTN];
      ctl_word[`HPSC_BIT_PF_EN]  = r_q.pf_en & cap_word[`HPSC_BIT_PWR_CTL];
    end
  end

  assign evt_in = {FAULT_EVT_IN, BUTTON_EVT_IN};
  assign evt_en = {ctl_word[`HPSC_BIT_PF_EN], ctl_word[`HPSC_BIT_ABP_EN]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_evt
      assign evt_fire[gi] = evt_in[gi] & evt_en[gi];
    end
  endgenerate

  assign ee_cap_wr = EE_WR_IN.wr & IS_DOWNSTREAM_IN & (EE_WR_IN.addr == `HPSC_OFS_SLOT_CAP);
  assign ee_ctl_wr = EE_WR_IN.wr & IS_DOWNSTREAM_IN & (EE_WR_IN.addr == `HPSC_OFS_SLOT_CTL);
  assign sw_ctl_wr = CFG_REQ_IN.wr & IS_DOWNSTREAM_IN & (CFG_REQ_IN.addr == `HPSC_OFS_SLOT_CTL);
  assign msg_trig  = ee_cap_wr | (IS_DOWNSTREAM_IN & DLL_UP_IN & ~r_q.dll_up);

  always_comb begin
    r_d        = r_q;
    r_d.dll_up = DLL_UP_IN;
    // capability fields change only through the serial EEPROM or I2C path
    if (ee_cap_wr) begin
      r_d.surprise  = EE_WR_IN.data[`HPSC_BIT_SURPRISE];
      r_d.plv       = EE_WR_IN.data[`HPSC_PLV_MSB:`HPSC_PLV_LSB];
      r_d.pls       = EE_WR_IN.data[`HPSC_PLS_MSB:`HPSC_PLS_LSB];
      r_d.interlock = EE_WR_IN.data[`HPSC_BIT_INTERLOCK];
      r_d.slot_num  = EE_WR_IN.data[`HPSC_PSN_MSB:`HPSC_PSN_LSB];
    end
    if (sw_ctl_wr) begin
      if (cap_word[`HPSC_BIT_ATTN_BTN]) begin
        r_d.abp_en = CFG_REQ_IN.wdata[`HPSC_BIT_ABP_EN];
      end
      if (cap_word[`HPSC_BIT_PWR_CTL]) begin
        r_d.pf_en = CFG_REQ_IN.wdata[`HPSC_BIT_PF_EN];
      end
    end
    // the EEPROM path wins over a software write in the same cycle
    if (ee_ctl_wr) begin
      r_d.abp_en = EE_WR_IN.data[`HPSC_BIT_ABP_EN];
      r_d.pf_en  = EE_WR_IN.data[`HPSC_BIT_PF_EN];
    end
    r_d.rvalid = CFG_REQ_IN.rd;
    r_d.rdata  = 32'h0000_0000;
    if (CFG_REQ_IN.rd) begin
      if (CFG_REQ_IN.addr == `HPSC_OFS_SLOT_CAP) begin
        r_d.rdata = cap_word;
      end else if (CFG_REQ_IN.addr == `HPSC_OFS_SLOT_CTL) begin
        r_d.rdata = ctl_word;
      end
    end
    r_d.led_n = hp_cap ? ~PWR_IND_ON_IN : 1'b1;
    r_d.int_p = (|evt_fire) & (PWR_STATE_IN == `HPSC_PM_D0);
    r_d.pme_p = (|evt_fire) & (PWR_STATE_IN == `HPSC_PM_D3HOT);
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      r_q           <= '0;
      r_q.plv       <= `HPSC_RST_PLV;
      r_q.pls       <= `HPSC_RST_PLS;
      r_q.surprise  <= `HPSC_RST_SURPRISE;
      r_q.interlock <= `HPSC_RST_INTERLOCK;
      r_q.slot_num  <= `HPSC_RST_PSN;
      r_q.led_n     <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  hpsc_msg_gen u_msg (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RST_N_IN),
    .trig_in  (msg_trig),
    .value_in (r_d.plv),
    .scale_in (r_d.pls),
    .ready_in (MSG_READY_IN),
    .msg_out  (MSG_OUT)
  );

  assign CFG_RDATA_OUT        = r_q.rdata;
  assign CFG_RVALID_OUT       = r_q.rvalid;
  assign SLOT_POWER_LED_N_OUT = r_q.led_n;
  assign NOTIFY_INT_OUT       = r_q.int_p;
  assign NOTIFY_PME_OUT       = r_q.pme_p;

endmodule
`default_nettype wire

// ### tb/hpsc_slot_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hpsc_slot_checker
  import hpsc_pkg::*;
(
  input wire logic          CLK_SYS_IN,
  input wire logic          RST_N_IN,
  input wire logic          IS_DOWNSTREAM_IN,
  input wire logic          PARALLEL_HP_IN,
  input wire logic          SERIAL_PORT_IN,
  input wire logic          EXPANDER_FOUND_IN,
  input wire logic [2:0]    STRAP_ADDR_IN,
  input wire logic [7:0]    EXP_SLOT_HI_IN,
  input wire logic [1:0]    PWR_STATE_IN,
  input wire hpsc_cfg_req_t CFG_REQ_IN,
  input wire logic          MSG_READY_IN,
  input wire logic [31:0]   CFG_RDATA_OUT,
  input wire logic          NOTIFY_INT_OUT,
  input wire hpsc_msg_t     MSG_OUT
);
  logic ser;
  logic hp;
  logic cap_rd;
  assign ser = SERIAL_PORT_IN & EXPANDER_FOUND_IN;
  assign hp = IS_DOWNSTREAM_IN & (PARALLEL_HP_IN | ser);
  assign cap_rd = CFG_REQ_IN.rd && CFG_REQ_IN.addr == 12'h07C;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  AST_HP_CAP: assert property (cap_rd |=> CFG_RDATA_OUT[6] == $past(hp)
    && CFG_RDATA_OUT[4] == $past(hp)) else $error("capability bits wrong");
  AST_NO_CMD: assert property (cap_rd |=> !CFG_RDATA_OUT[18])
    else $error("bit 18 set");
  AST_INTERLOCK: assert property (cap_rd && !ser |=> !CFG_RDATA_OUT[17])
    else $error("interlock on non-serial port");
  AST_STRAP: assert property (cap_rd && IS_DOWNSTREAM_IN && !ser |=>
    CFG_RDATA_OUT[21:19] == $past(STRAP_ADDR_IN) && CFG_RDATA_OUT[31:27] == 5'h00)
    else $error("strap slot bits wrong");
  AST_EXP_SLOT: assert property (cap_rd && IS_DOWNSTREAM_IN && ser |=>
    CFG_RDATA_OUT[31:24] == $past(EXP_SLOT_HI_IN)) else $error("expander slot bits wrong");
  AST_UPSTREAM: assert property (CFG_REQ_IN.rd && !IS_DOWNSTREAM_IN |=>
    CFG_RDATA_OUT == 32'h0) else $error("upstream read not zero");
  AST_CTL_GATED: assert property (CFG_REQ_IN.rd && CFG_REQ_IN.addr == 12'h080 && !hp |=>
    CFG_RDATA_OUT[1:0] == 2'h0) else $error("enable reads set without capability");
  AST_MSG_HOLD: assert property (MSG_OUT.valid && !MSG_READY_IN |=> MSG_OUT.valid)
    else $error("message dropped before accept");
  AST_INT_D0: assert property (NOTIFY_INT_OUT |-> $past(PWR_STATE_IN) == 2'h0)
    else $error("interrupt outside D0");
endmodule
bind hpsc_slot_regs hpsc_slot_checker chk (.CLK_SYS_IN, .RST_N_IN, .IS_DOWNSTREAM_IN,
  .PARALLEL_HP_IN, .SERIAL_PORT_IN, .EXPANDER_FOUND_IN, .STRAP_ADDR_IN, .EXP_SLOT_HI_IN,
  .PWR_STATE_IN, .CFG_REQ_IN, .MSG_READY_IN, .CFG_RDATA_OUT, .NOTIFY_INT_OUT, .MSG_OUT);
`default_nettype wire

// ### tb/hpsc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module hpsc_link_partner
  import hpsc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire hpsc_msg_t  msg_in,
  input  wire logic [3:0] stall_in,
  output logic            ready_out,
  output logic [7:0]      value_out,
  output logic [1:0]      scale_out,
  output logic [7:0]      count_out
);
  logic [3:0] wait_q;
  // accepts only after stall_in cycles of pending message
  assign ready_out = msg_in.valid && (wait_q >= stall_in);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 4'h0;
      value_out <= 8'h00;
      scale_out <= 2'h0;
      count_out <= 8'h00;
    end else if (ready_out) begin
      wait_q <= 4'h0;
      value_out <= msg_in.value;
      scale_out <= msg_in.scale;
      count_out <= count_out + 8'h01;
    end else if (msg_in.valid) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/hot_plug_slot_capability_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hot_plug_slot_capability_control_bench;
  import hpsc_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n, down, par, ser, expf, dll, btn, flt, ind, rdy, rv, led_n, n_int, n_pme;
  logic [2:0]    strap;
  logic [7:0]    exp_hi, p_val, p_cnt;
  logic [1:0]    pst, p_scl;
  logic [3:0]    stall;
  logic [31:0]   rdata;
  hpsc_cfg_req_t req;
  hpsc_ee_wr_t   ee;
  hpsc_msg_t     msg;
  int            mismatches = 0;
  int            samples_checked = 0;
  always #10 clk = ~clk;
  hpsc_slot_regs dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .IS_DOWNSTREAM_IN(down),
    .PARALLEL_HP_IN(par), .SERIAL_PORT_IN(ser), .EXPANDER_FOUND_IN(expf),
    .STRAP_ADDR_IN(strap), .EXP_SLOT_HI_IN(exp_hi), .DLL_UP_IN(dll), .PWR_STATE_IN(pst),
    .BUTTON_EVT_IN(btn), .FAULT_EVT_IN(flt), .PWR_IND_ON_IN(ind), .CFG_REQ_IN(req),
    .EE_WR_IN(ee), .MSG_READY_IN(rdy), .CFG_RDATA_OUT(rdata), .CFG_RVALID_OUT(rv),
    .SLOT_POWER_LED_N_OUT(led_n), .NOTIFY_INT_OUT(n_int), .NOTIFY_PME_OUT(n_pme), .MSG_OUT(msg));
  hpsc_link_partner far (.clk_in(clk), .rst_n_in(rst_n), .msg_in(msg), .stall_in(stall),
    .ready_out(rdy), .value_out(p_val), .scale_out(p_scl), .count_out(p_cnt));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task tick;
    @(posedge clk) #2;
  endtask
  // r=1 reads and expects d, r=0 writes d
  task cfg(input logic r, input logic [11:0] a, input logic [31:0] d);
    tick;
    req = '{rd: r, wr: !r, addr: a, wdata: d};
    tick;
    req = '0;
    if (r) check(rv ? rdata : ~d, d);
  endtask
  task eew(input logic [31:0] d);
    tick;
    ee = '{wr: 1'b1, addr: 12'h07C, data: d};
    tick;
    ee = '0;
  endtask
  task evt(input logic [1:0] s, input logic b, input logic [1:0] e);
    pst = s;
    tick;
    btn = b;
    flt = !b;
    tick;
    btn = 1'b0;
    flt = 1'b0;
    check({30'h0, n_int, n_pme}, {30'h0, e});
  endtask
  initial begin
    {rst_n, dll, btn, flt, ind, ser, expf} = '0;
    {down, par} = 2'b11;
    strap = 3'h5;
    exp_hi = 8'hA6;
    pst = 2'h0;
    stall = 4'h3;
    req = '0;
    ee = '0;
    repeat (16) tick;
    rst_n = 1'b1;
    cfg(1, 12'h07C, {10'h000, 3'h5, 4'h0, 8'h19, 7'h5F});
    cfg(0, 12'h07C, 32'hFFFFFFFF);
    cfg(1, 12'h07C, {10'h000, 3'h5, 4'h0, 8'h19, 7'h5F});
    cfg(1, 12'h080, 32'h0);
    cfg(0, 12'h080, 32'h3);
    cfg(1, 12'h080, 32'h3);
    cfg(1, 12'h0A4, 32'h0);
    for (int s = 0; s < 4; s++) evt(s[1:0], 1'b1, {s == 0, s == 3});
    evt(2'h3, 1'b0, 2'h1);
    evt(2'h0, 1'b0, 2'h2);
    ind = 1'b1;
    tick;
    check({31'h0, led_n}, 32'h0);
    eew({13'h0F3, 1'b0, 1'b1, 2'h2, 8'h20, 7'h00});
    repeat (8) tick;
    check({14'h0, p_cnt, p_val, p_scl}, {14'h0, 8'h01, 8'h20, 2'h2});
    stall = 4'h0;
    dll = 1'b1;
    repeat (4) tick;
    check({24'h0, p_cnt}, 32'h2);
    {par, ser, expf} = 3'b011;
    cfg(1, 12'h07C, {8'hA6, 5'h13, 4'h6, 8'h20, 7'h5F});
    expf = 1'b0;
    cfg(1, 12'h07C, {5'h00, 5'h1E, 3'h5, 4'h2, 8'h20, 7'h00});
    cfg(1, 12'h080, 32'h0);
    down = 1'b0;
    cfg(1, 12'h07C, 32'h0);
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
